// file: include/pof_params.svh
// Overview of operation
// - each color has eight-bit even and odd ports
// - single mode: even port only, odd released
// - split mode alternates pixels between both ports
// - pair mode updates both ports every second pixel
// - interleaved mode updates one port per pixel
// - first pixel after line sync goes even
// - latency from sampling to outputs varies with buffer fill, outHold and phase tap
// - phase shift moves data, strobes, sync together
// - single mode strobe runs at pixel rate
// - split mode strobe runs at half pixel rate
// - strobe clock pair derived from pixel clock
// - inactive detect releases all pixel outputs
// - only leading line sync edge counts, polarity-selected
`ifndef POF_PARAMS_SVH
`define POF_PARAMS_SVH
`define POF_PIX_WIDTH 8
`define POF_PIX_MSB 7
`define POF_FIFO_DEPTH 16
`define POF_PIX_DIV 2
`define POF_PHASE_TAPS 8
`define POF_SPLIT_SINGLE 1'b0
`define POF_PAIR_PARALLEL 1'b1
`define POF_POL_FALLING 1'b0
`define POF_STROBE_RESET 1'b0
`endif

// file: include/pof_pkg.sv
`include "pof_params.svh"
package pof_pkg;
	typedef enum logic [1:0] {
		POF_MODE_SINGLE,
		POF_MODE_PARALLEL,
		POF_MODE_INTERLEAVED
	} pof_mode_t;

	typedef enum logic {
		POF_SLOT_EVEN,
		POF_SLOT_ODD
	} pof_slot_t;

	function automatic pof_mode_t pof_mode_decode(input logic split, input logic pair);
		if (split == `POF_SPLIT_SINGLE) begin
			return POF_MODE_SINGLE;
		end else if (pair == `POF_PAIR_PARALLEL) begin
			return POF_MODE_PARALLEL;
		end else begin
			return POF_MODE_INTERLEAVED;
		end
	endfunction : pof_mode_decode
endpackage : pof_pkg

// file: rtl/pof_fifo.sv
`timescale 1ns/1ps
`include "pof_params.svh"
module pof_fifo import pof_pkg::*; #(
	parameter int WIDTH = 25,
	parameter int DEPTH = `POF_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q;
	logic [AW:0] wrPtr_d;
	logic [AW:0] rdPtr_q;
	logic [AW:0] rdPtr_d;
	logic push;
	logic pop;
	logic full;
	logic empty;

	always_comb begin
		empty = (wrPtr_q == rdPtr_q);
		full = (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]) && (wrPtr_q[AW] != rdPtr_q[AW]);
		inReady = !full;
		outValid = !empty;
		push = inValid && !full && clkEn;
		pop = outReady && !empty && clkEn;
		wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
		rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
		outData = mem[rdPtr_q[AW-1:0]];
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end
endmodule : pof_fifo

// file: rtl/pof_formatter.sv
`timescale 1ns/1ps
`include "pof_params.svh"
module pof_formatter import pof_pkg::*; #(
	parameter int PIX_W = `POF_PIX_WIDTH,
	parameter int FIFO_DEPTH = `POF_FIFO_DEPTH,
	parameter int PIX_DIV = `POF_PIX_DIV,
	parameter int PHASE_TAPS = `POF_PHASE_TAPS
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic pixValid,
	output logic pixReady,
	input wire logic [PIX_W-1:0] pixRed,
	input wire logic [PIX_W-1:0] pixGreen,
	input wire logic [PIX_W-1:0] pixBlue,
	input wire logic lineSyncIn,
	input wire logic lineSyncPolarity,
	input wire logic twoPortSplit,
	input wire logic simultaneous_pair_select,
	input wire logic activity_detect,
	input wire logic [$clog2(PHASE_TAPS)-1:0] phaseSel,
	input wire logic outHold,
	output logic [PIX_W-1:0] evenRed,
	output logic [PIX_W-1:0] evenGreen,
	output logic [PIX_W-1:0] evenBlue,
	output logic evenOe,
	output logic [PIX_W-1:0] oddRed,
	output logic [PIX_W-1:0] oddGreen,
	output logic [PIX_W-1:0] oddBlue,
	output logic oddOe,
	output logic output_strobe_clock,
	output logic output_strobe_clock_n,
	output logic line_sync_out
);
	// packed widths: one pixel, one buffered word, one output bundle
	localparam int PW = 3 * PIX_W;
	localparam int FW = PW + 1;
	localparam int BW = 2 * PW + 4;
	localparam int DW = $clog2(PIX_DIV);
	localparam logic [DW-1:0] DIV_LAST = DW'(PIX_DIV - 1);
	localparam logic [DW-1:0] DIV_HALF = DW'(PIX_DIV / 2);

	// line start detection
	logic lsPrev_q;
	logic lsPrev_d;
	logic lsPend_q;
	logic lsPend_d;
	logic lsArmed_q;
	logic lsArmed_d;
	logic lsEdge;
	logic pushLineStart;

	// fifo link
	logic fifoInValid;
	logic fifoInReady;
	logic [FW-1:0] fifoInData;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [FW-1:0] fifoOutData;

	// pixel slot formatting
	pof_mode_t mode;
	pof_slot_t slot_q;
	pof_slot_t slot_d;
	logic [DW-1:0] divCnt_q;
	logic [DW-1:0] divCnt_d;
	logic [PW-1:0] holdPix_q;
	logic [PW-1:0] holdPix_d;
	logic [PW-1:0] evenPix_q;
	logic [PW-1:0] evenPix_d;
	logic [PW-1:0] oddPix_q;
	logic [PW-1:0] oddPix_d;
	logic evenOn_q;
	logic evenOn_d;
	logic oddOn_q;
	logic oddOn_d;
	logic lsOut_q;
	logic lsOut_d;
	logic strobe_q;
	logic strobe_d;
	logic pixTick;
	logic midTick;
	logic take;
	logic takeLineStart;
	logic [PW-1:0] takePix;
	pof_slot_t curSlot;

	// aligned output bundle
	logic [BW-1:0] preBundle;
	logic [BW-1:0] postBundle;
	logic [PW-1:0] outEvenPix;
	logic [PW-1:0] outOddPix;
	logic outEvenOn;
	logic outOddOn;
	logic outStrobe;
	logic outLineSync;

	// only the leading edge selected by polarity marks a line start
	// edges count only once the previous sync level has been seen after reset
	always_comb begin
		lsPrev_d = clkEn ? lineSyncIn : lsPrev_q;
		lsArmed_d = clkEn ? 1'b1 : lsArmed_q;
		if (lineSyncPolarity == `POF_POL_FALLING) begin
			lsEdge = lsArmed_q && lsPrev_q && !lineSyncIn;
		end else begin
			lsEdge = lsArmed_q && !lsPrev_q && lineSyncIn;
		end
		// an edge waits in lsPend until a pixel arrives to carry it
		pushLineStart = lsPend_q || lsEdge;
		fifoInValid = pixValid;
		pixReady = fifoInReady;
		fifoInData = {pushLineStart, pixRed, pixGreen, pixBlue};
		lsPend_d = lsPend_q;
		if (clkEn) begin
			// a push takes the pending mark; an edge in the same cycle tags that push
			if (pixValid && fifoInReady) begin
				lsPend_d = 1'b0;
			end else if (lsEdge) begin
				lsPend_d = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lsPrev_q <= 1'b0;
			lsPend_q <= 1'b0;
			lsArmed_q <= 1'b0;
		end else begin
			lsPrev_q <= lsPrev_d;
			lsPend_q <= lsPend_d;
			lsArmed_q <= lsArmed_d;
		end
	end

	// the buffer absorbs input bursts; when full, pixReady holds the sender off
	pof_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(fifoInData),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	// one pixel slot every PIX_DIV cycles, strobes derived from the same divider
	always_comb begin
		mode = pof_mode_decode(twoPortSplit, simultaneous_pair_select);
		pixTick = (divCnt_q == '0);
		midTick = (divCnt_q == DIV_HALF);
		take = pixTick && fifoOutValid && !outHold;
		fifoOutReady = pixTick && !outHold;
		// the line-start tag rides in the top bit of each buffered word
		takeLineStart = fifoOutData[PW];
		takePix = fifoOutData[PW-1:0];
		curSlot = takeLineStart ? POF_SLOT_EVEN : slot_q;
		slot_d = slot_q;
		holdPix_d = holdPix_q;
		evenPix_d = evenPix_q;
		oddPix_d = oddPix_q;
		evenOn_d = evenOn_q;
		oddOn_d = oddOn_q;
		lsOut_d = lsOut_q;
		if (clkEn) begin
			// the odd port is released as soon as single mode is chosen
			if (mode == POF_MODE_SINGLE) begin
				oddOn_d = 1'b0;
			end
			if (pixTick) begin
				lsOut_d = 1'b0;
			end
			if (take) begin
				lsOut_d = takeLineStart;
				case (mode)
					POF_MODE_SINGLE: begin
						evenPix_d = takePix;
						evenOn_d = 1'b1;
						oddOn_d = 1'b0;
						slot_d = POF_SLOT_EVEN;
					end
					POF_MODE_PARALLEL: begin
						evenOn_d = 1'b1;
						oddOn_d = 1'b1;
						if (curSlot == POF_SLOT_EVEN) begin
							// the even pixel waits here for its odd partner
							holdPix_d = takePix;
							slot_d = POF_SLOT_ODD;
						end else begin
							evenPix_d = holdPix_q;
							oddPix_d = takePix;
							slot_d = POF_SLOT_EVEN;
						end
					end
					POF_MODE_INTERLEAVED: begin
						evenOn_d = 1'b1;
						oddOn_d = 1'b1;
						if (curSlot == POF_SLOT_EVEN) begin
							evenPix_d = takePix;
							slot_d = POF_SLOT_ODD;
						end else begin
							oddPix_d = takePix;
							slot_d = POF_SLOT_EVEN;
						end
					end
					default: begin
						slot_d = POF_SLOT_EVEN;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_q <= POF_SLOT_EVEN;
			holdPix_q <= '0;
			evenPix_q <= '0;
			oddPix_q <= '0;
			evenOn_q <= 1'b0;
			oddOn_q <= 1'b0;
			lsOut_q <= 1'b0;
		end else begin
			slot_q <= slot_d;
			holdPix_q <= holdPix_d;
			evenPix_q <= evenPix_d;
			oddPix_q <= oddPix_d;
			evenOn_q <= evenOn_d;
			oddOn_q <= oddOn_d;
			lsOut_q <= lsOut_d;
		end
	end

	// pixel slot divider and output strobe clock
	always_comb begin
		divCnt_d = divCnt_q;
		strobe_d = strobe_q;
		if (clkEn) begin
			divCnt_d = (divCnt_q == DIV_LAST) ? '0 : divCnt_q + 1'b1;
			// full pixel rate in single mode, half rate when split
			// a line-start pixel restarts the strobe so it stays in step with the sync
			if (take && takeLineStart) begin
				strobe_d = `POF_STROBE_RESET;
			end else if (mode == POF_MODE_SINGLE) begin
				if (pixTick) begin
					strobe_d = 1'b0;
				end else if (midTick) begin
					strobe_d = 1'b1;
				end
			end else if (pixTick) begin
				strobe_d = !strobe_q;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			divCnt_q <= '0;
			strobe_q <= `POF_STROBE_RESET;
		end else begin
			divCnt_q <= divCnt_d;
			strobe_q <= strobe_d;
		end
	end

	// data, strobe and line sync share one delay tap so phase moves them together
	always_comb begin
		preBundle = {evenPix_q, oddPix_q, evenOn_q, oddOn_q, strobe_q, lsOut_q};
	end

	pof_phase_delay #(
		.WIDTH(BW),
		.TAPS(PHASE_TAPS)
	) u_phase (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.tapSel(phaseSel),
		.inBundle(preBundle),
		.outBundle(postBundle)
	);

	always_comb begin
		{outEvenPix, outOddPix, outEvenOn, outOddOn, outStrobe, outLineSync} = postBundle;
		evenRed = outEvenPix[3*PIX_W-1:2*PIX_W];
		evenGreen = outEvenPix[2*PIX_W-1:PIX_W];
		evenBlue = outEvenPix[PIX_W-1:0];
		oddRed = outOddPix[3*PIX_W-1:2*PIX_W];
		oddGreen = outOddPix[2*PIX_W-1:PIX_W];
		oddBlue = outOddPix[PIX_W-1:0];
		// the enables model the pad drivers; released ports keep their last data
		evenOe = outEvenOn && activity_detect;
		oddOe = outOddOn && activity_detect;
		output_strobe_clock = outStrobe;
		output_strobe_clock_n = !outStrobe;
		line_sync_out = outLineSync;
	end
endmodule : pof_formatter

// file: rtl/pof_phase_delay.sv
`timescale 1ns/1ps
`include "pof_params.svh"
module pof_phase_delay import pof_pkg::*; #(
	parameter int WIDTH = 52,
	parameter int TAPS = `POF_PHASE_TAPS
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic [$clog2(TAPS)-1:0] tapSel,
	input wire logic [WIDTH-1:0] inBundle,
	output logic [WIDTH-1:0] outBundle
);
	logic [WIDTH-1:0] stage_q [TAPS];
	logic [WIDTH-1:0] stage_d [TAPS];

	// one common tap for the whole bundle keeps every signal aligned
	genvar i;
	generate
		for (i = 0; i < TAPS; i++) begin : g_stage
			if (i == 0) begin : g_head
				always_comb begin
					stage_d[i] = clkEn ? inBundle : stage_q[i];
				end
			end else begin : g_tail
				always_comb begin
					stage_d[i] = clkEn ? stage_q[i-1] : stage_q[i];
				end
			end

			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					stage_q[i] <= '0;
				end else begin
					stage_q[i] <= stage_d[i];
				end
			end
		end
	endgenerate

	always_comb begin
		outBundle = stage_q[tapSel];
	end
endmodule : pof_phase_delay

// file: verif/pof_formatter_properties.sv
`timescale 1ns/1ps
module pof_formatter_properties import pof_pkg::*; #(
	parameter int PIX_W = 8,
	parameter int PHASE_TAPS = 8
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic twoPortSplit,
	input wire logic simultaneous_pair_select,
	input wire logic activity_detect,
	input wire logic [$clog2(PHASE_TAPS)-1:0] phaseSel,
	input wire logic [PIX_W-1:0] evenRed,
	input wire logic evenOe,
	input wire logic [PIX_W-1:0] oddRed,
	input wire logic oddOe,
	input wire logic output_strobe_clock,
	input wire logic output_strobe_clock_n,
	input wire logic line_sync_out
);
	logic [$clog2(PHASE_TAPS)+1:0] cfg_q, cfg_d;
	logic [3:0] stCnt_q, stCnt_d;
	logic settled;
	// settled once mode and phase stood still long enough to flush the pipe
	always_comb begin
		cfg_d = {twoPortSplit, simultaneous_pair_select, phaseSel};
		stCnt_d = (cfg_d != cfg_q) ? 4'h0 : stCnt_q + {3'h0, stCnt_q != 4'hf};
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= '0;
			stCnt_q <= 4'h0;
		end else begin
			cfg_q <= cfg_d;
			stCnt_q <= stCnt_d;
		end
	end
	assign settled = stCnt_q >= 4'hc;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	property p_strobe_pair;
		output_strobe_clock_n == !output_strobe_clock;
	endproperty
	a_strobe_pair: assert property (p_strobe_pair) else $error("strobe pair differs");
	property p_idle_release;
		!activity_detect |-> !evenOe && !oddOe;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("port driven idle");
	property p_single_odd;
		settled && !twoPortSplit |-> !oddOe;
	endproperty
	a_single_odd: assert property (p_single_odd) else $error("odd driven single");
	property p_line_pulse;
		$rose(line_sync_out) |=> line_sync_out ##1 !line_sync_out;
	endproperty
	a_line_pulse: assert property (p_line_pulse) else $error("sync width");
	property p_single_rate;
		settled && !twoPortSplit |-> output_strobe_clock != $past(output_strobe_clock);
	endproperty
	a_single_rate: assert property (p_single_rate) else $error("strobe rate single");
	property p_dual_rate;
		settled && twoPortSplit && !line_sync_out && $changed(output_strobe_clock)
			|=> $stable(output_strobe_clock) || line_sync_out;
	endproperty
	a_dual_rate: assert property (p_dual_rate) else $error("strobe rate dual");
	property p_interleave;
		settled && twoPortSplit && !simultaneous_pair_select && $changed(evenRed)
			|-> $stable(oddRed);
	endproperty
	a_interleave: assert property (p_interleave) else $error("both ports moved");
	property p_parallel;
		settled && twoPortSplit && simultaneous_pair_select && $changed(evenRed)
			|=> $stable(evenRed)[*3];
	endproperty
	a_parallel: assert property (p_parallel) else $error("pair too often");
	c_dual_sync: cover property (twoPortSplit && line_sync_out);
	c_pair: cover property (settled && simultaneous_pair_select && $changed(oddRed));
	c_idle: cover property (settled && !activity_detect);
endmodule : pof_formatter_properties
bind pof_formatter pof_formatter_properties #(.PIX_W(PIX_W), .PHASE_TAPS(PHASE_TAPS))
	pof_formatter_properties_inst (.sys_clk, .rst_b, .twoPortSplit, .simultaneous_pair_select,
	.activity_detect, .phaseSel, .evenRed, .evenOe, .oddRed, .oddOe, .output_strobe_clock,
	.output_strobe_clock_n, .line_sync_out);

// file: verif/pof_sink.sv
`timescale 1ns/1ps
module pof_sink import pof_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic stallReq,
	input wire logic output_strobe_clock,
	input wire logic [7:0] evenRed,
	output logic outHold,
	output logic [7:0] lastRed
);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) outHold <= 1'b0;
		else outHold <= stallReq;
	end
	always_ff @(posedge output_strobe_clock or negedge rst_b) begin
		if (!rst_b) lastRed <= 8'h00;
		else lastRed <= evenRed;
	end
endmodule : pof_sink

// file: verif/tb.sv
`timescale 1ns/1ps
module tb import pof_pkg::*; ;
	logic sys_clk = 1'b0, rst_b = 1'b0, pixValid = 1'b0, lineSyncIn = 1'b1;
	logic lineSyncPolarity = 1'b0, twoPortSplit = 1'b0, simultaneous_pair_select = 1'b0;
	logic activity_detect = 1'b1, stallReq = 1'b0, oddSlot = 1'b0;
	logic [7:0] pixRed = 8'h00, pixGreen = 8'h00, pixBlue = 8'h00, sinkRed;
	logic [7:0] evenRed, evenGreen, evenBlue, oddRed, oddGreen, oddBlue;
	logic [2:0] phaseSel = 3'h0;
	logic pixReady, evenOe, oddOe, output_strobe_clock, output_strobe_clock_n;
	logic line_sync_out, outHold;
	logic [23:0] prevE, prevO, gotE[$], gotO[$], expE[$], expO[$];
	int fail_count = 0;
	int n_tests = 0;
	always #4 sys_clk = ~sys_clk;
	pof_formatter pof_formatter_inst (.sys_clk, .rst_b, .clkEn(1'b1), .pixValid, .pixReady,
		.pixRed, .pixGreen, .pixBlue, .lineSyncIn, .lineSyncPolarity, .twoPortSplit,
		.simultaneous_pair_select, .activity_detect, .phaseSel, .outHold, .evenRed,
		.evenGreen, .evenBlue, .evenOe, .oddRed, .oddGreen, .oddBlue, .oddOe,
		.output_strobe_clock, .output_strobe_clock_n, .line_sync_out);
	pof_sink pof_sink_inst (.sys_clk, .rst_b, .stallReq, .output_strobe_clock, .evenRed,
		.outHold, .lastRed(sinkRed));
	always @(posedge sys_clk) begin
		if (rst_b && {evenRed, evenGreen, evenBlue} !== prevE) begin
			prevE = {evenRed, evenGreen, evenBlue};
			gotE.push_back(prevE);
		end
		if (rst_b && {oddRed, oddGreen, oddBlue} !== prevO) begin
			prevO = {oddRed, oddGreen, oddBlue};
			gotO.push_back(prevO);
		end
	end
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chkq();
		chk(24'(gotE.size()), 24'(expE.size()));
		chk(24'(gotO.size()), 24'(expO.size()));
		foreach (expE[i]) chk(gotE[i], expE[i]);
		foreach (expO[i]) chk(gotO[i], expO[i]);
		chk({16'h0000, sinkRed}, {16'h0000, expE[expE.size() - 1][23:16]});
	endtask : chkq
	task automatic idle(input int n);
		pixValid <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : idle
	task automatic restart(input logic split, input logic pair, input logic pol,
		input logic [2:0] ph);
		rst_b <= 1'b0;
		twoPortSplit <= split;
		simultaneous_pair_select <= pair;
		lineSyncPolarity <= pol;
		lineSyncIn <= !pol;
		phaseSel <= ph;
		oddSlot = 1'b0;
		idle(10);
		prevE = 24'h0000;
		prevO = 24'h0000;
		gotE.delete();
		gotO.delete();
		expE.delete();
		expO.delete();
		rst_b <= 1'b1;
		// a quiet cycle lets the sync edge detector take in the idle level
		idle(1);
	endtask : restart
	// pushes n pixels and files each under the port it should leave on
	task automatic burst(input logic [7:0] base, input int n);
		logic [7:0] v;
		for (int i = 0; i < n; i++) begin
			v = base + 8'(i);
			pixRed <= v;
			pixGreen <= ~v;
			pixBlue <= v ^ 8'h5a;
			pixValid <= 1'b1;
			@(posedge sys_clk);
			while (pixReady !== 1'b1) @(posedge sys_clk);
			if (oddSlot) expO.push_back({v, ~v, v ^ 8'h5a});
			else expE.push_back({v, ~v, v ^ 8'h5a});
			oddSlot = twoPortSplit & !oddSlot;
		end
	endtask : burst
	initial begin
		#20000;
		fail_count++;
		end_of_test();
	end
	initial begin
		restart(1'b0, 1'b0, 1'b0, 3'h3);
		burst(8'h10, 4);
		idle(30);
		chk({23'h0, oddOe}, 24'h0000);
		chkq();
		// leading edge before the pixels, trailing edge between them
		for (int m = 0; m < 2; m++) begin
			restart(1'b1, 1'(m), 1'(m), 3'(2 * m));
			lineSyncIn <= 1'(m);
			idle(1);
			burst(8'h20, 2);
			lineSyncIn <= 1'(!m);
			idle(1);
			burst(8'h30, 2);
			idle(30);
			chkq();
		end
		restart(1'b1, 1'b0, 1'b0, 3'h0);
		burst(8'h40, 3);
		lineSyncIn <= 1'b0;
		oddSlot = 1'b0;
		idle(1);
		lineSyncIn <= 1'b1;
		burst(8'h50, 2);
		idle(30);
		chkq();
		restart(1'b0, 1'b0, 1'b0, 3'h7);
		stallReq <= 1'b1;
		idle(3);
		burst(8'h60, 16);
		idle(2);
		chk({23'h0, pixReady}, 24'h0000);
		stallReq <= 1'b0;
		idle(60);
		chk({22'h0, evenOe, oddOe}, 24'h0002);
		activity_detect <= 1'b0;
		idle(1);
		chk({22'h0, evenOe, oddOe}, 24'h0000);
		activity_detect <= 1'b1;
		chkq();
		end_of_test();
	end
endmodule : tb
